/* File: core/loop_det_cfg.svh */
// Constants of the loop detector output control block
`ifndef LOOP_DET_CFG_SVH
`define LOOP_DET_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_KHZ          100000
`define DELAY_MS         2000
`define EXTEND_MS        5000
`define PULSE_MS         250
`define RETUNE_MS        2000
`define TICK_MS          250
`define DEBOUNCE_MS      20
`define HOLD_MIN_MS      300000
`define DELAY_CYC        (`DELAY_MS * `CLK_KHZ)
`define EXTEND_CYC       (`EXTEND_MS * `CLK_KHZ)
`define PULSE_CYC        (`PULSE_MS * `CLK_KHZ)
`define RETUNE_CYC       (`RETUNE_MS * `CLK_KHZ)
`define TICK_CYC         (`TICK_MS * `CLK_KHZ)
`define DEBOUNCE_CYC     (`DEBOUNCE_MS * `CLK_KHZ)
`define HOLD_TICKS       (`HOLD_MIN_MS / `TICK_MS)

// ----------------------------------------
// Aux output modes (switch 3, switch 4)
// ----------------------------------------
`define AUX_FAULT        2'h0
`define AUX_EXIT         2'h1
`define AUX_PRESENCE     2'h2
`define AUX_ENTRY        2'h3

// ----------------------------------------
// Fault codes (number of blinks)
// ----------------------------------------
`define CODE_NONE        2'h0
`define CODE_OPEN        2'h1
`define CODE_SHORT       2'h2
`define CODE_CHANGE      2'h3

// ----------------------------------------
// Register map (byte offsets) and fields
// ----------------------------------------
`define REG_STATUS       4'h0
`define REG_SWITCH       4'h4
`define REG_CTRL         4'h8
`define CTRL_ENABLE_BIT  0
`define CTRL_CLEAR_BIT   1
`define CTRL_RESET       1'h1

`endif

/* File: core/loop_det_pkg.sv */
// Types shared by the loop detector output control block
package loop_det_pkg;

  // Detection sequence
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_DETECT,
    ST_EXTEND
  } det_state_t;

  // Debounced switch settings, front and internal
  typedef struct packed {
    logic       fail_secure;
    logic       normal_pres;
    logic       extend_en;
    logic       delay_en;
    logic [1:0] freq;
    logic [1:0] aux_mode;
    logic [1:0] sens;
  } sw_cfg_t;

  // Loop monitor inputs
  typedef struct packed {
    logic low_supply;
    logic change;
    logic shorted;
    logic open;
  } loop_flags_t;

endpackage

/* File: core/loop_det_ctrl.sv */
// Output, timing, indicator and register logic of the loop detector
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "loop_det_cfg.svh"

module loop_det_ctrl
  import loop_det_pkg::*;
#(
  parameter int unsigned DELAY_CYC    = `DELAY_CYC,
  parameter int unsigned EXTEND_CYC   = `EXTEND_CYC,
  parameter int unsigned PULSE_CYC    = `PULSE_CYC,
  parameter int unsigned RETUNE_CYC   = `RETUNE_CYC,
  parameter int unsigned TICK_CYC     = `TICK_CYC,
  parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter int unsigned HOLD_TICKS   = `HOLD_TICKS
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic        VEHICLE,
  input  wire loop_flags_t LOOP_FLAGS,
  input  wire sw_cfg_t     SWITCHES,
  input  wire logic        RESET_BUTTON,
  output logic             PRESENCE_OUT,
  output logic             AUX_OUT,
  output logic             AUX_OUT_N,
  output logic             DETECT_LED,
  output logic             POWER_LED,
  output logic [1:0]       SENS_LEVEL,
  output logic             SENS_BOOST,
  output logic [1:0]       FREQ_SEL,
  output logic             RETUNE,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST
);

  // ----------------------------------------
  // Switch and button conditioning
  // ----------------------------------------
  // Raw samples, debounce counter and accepted settings
  logic [10:0] raw_sync1_reg;
  logic [10:0] raw_sync2_reg;
  logic [10:0] raw_last_reg;
  logic [31:0] bounce_cnt_reg;
  sw_cfg_t     cfg_reg;
  logic        button_reg;
  logic        button_last_reg;
  // Button shares the debounce, so any bounce restarts the wait for all
  wire         bounce_done = (bounce_cnt_reg >= DEBOUNCE_CYC - 1);
  wire         button_press = button_reg & ~button_last_reg;

  // Two-stage sync, then accept a value that held still for the debounce time
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      raw_sync1_reg   <= 11'h000;
      raw_sync2_reg   <= 11'h000;
      raw_last_reg    <= 11'h000;
      bounce_cnt_reg  <= 32'h0;
      cfg_reg         <= '0;
      button_reg      <= 1'b0;
      button_last_reg <= 1'b0;
    end else if (CLK_EN) begin
      raw_sync1_reg   <= {RESET_BUTTON, SWITCHES};
      raw_sync2_reg   <= raw_sync1_reg;
      raw_last_reg    <= raw_sync2_reg;
      button_last_reg <= button_reg;
      if (raw_sync2_reg != raw_last_reg) begin
        bounce_cnt_reg <= 32'h0;
      end else if (!bounce_done) begin
        bounce_cnt_reg <= bounce_cnt_reg + 32'h1;
      end else begin
        cfg_reg    <= sw_cfg_t'(raw_last_reg[9:0]);
        button_reg <= raw_last_reg[10];
      end
    end
  end

  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  // Slave state; only one access is in flight at a time
  logic        enable_reg;
  logic        sw_clear;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status_word;
  wire         bus_req  = AVS_READ | AVS_WRITE;
  wire         bus_done = bus_req & ~wait_reg;
  wire         hit_ctrl = (AVS_ADDRESS == `REG_CTRL);
  // Read select; the clear bit of control always reads zero
  wire [31:0]  rd_mux   = (AVS_ADDRESS == `REG_STATUS) ? status_word :
                          (AVS_ADDRESS == `REG_SWITCH) ? {22'h0, cfg_reg} :
                          hit_ctrl ? {31'h0, enable_reg} : 32'h0;
  // Clear strobe lasts only the answering cycle
  assign sw_clear = bus_done & AVS_WRITE & hit_ctrl & AVS_WRITEDATA[`CTRL_CLEAR_BIT];

  // One wait cycle per access; unmapped reads return zero, writes are dropped
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wait_reg   <= 1'b1;
      rdata_reg  <= 32'h0;
      enable_reg <= `CTRL_RESET;
    end else if (CLK_EN) begin
      wait_reg <= ~(bus_req & wait_reg);
      if (bus_req & wait_reg) begin
        rdata_reg <= rd_mux;
      end
      if (bus_done & AVS_WRITE & hit_ctrl) begin
        enable_reg <= AVS_WRITEDATA[`CTRL_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------
  // Time base for blink patterns and hold time
  // ----------------------------------------
  // Free-running divider; the tick count wraps every 16 ticks
  // All blink patterns share it, so the LEDs stay in step
  logic [31:0] tick_div_reg;
  logic [3:0]  tick_cnt_reg;
  wire         tick = (tick_div_reg == TICK_CYC - 1);

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_div_reg <= 32'h0;
      tick_cnt_reg <= 4'h0;
    end else if (CLK_EN) begin
      tick_div_reg <= tick ? 32'h0 : tick_div_reg + 32'h1;
      if (tick) begin
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Loop fault monitor
  // ----------------------------------------
  // Stored code, retune timer and clear sources
  logic [1:0]  code_reg;
  logic [31:0] retune_cnt_reg;
  logic        retuning_reg;
  // Either the button or software may clear the stored code
  wire         clear_code = button_press | sw_clear;
  wire         retune_end = retuning_reg & (retune_cnt_reg == RETUNE_CYC - 1);
  // Open and short follow the inputs; a change stays a fault until retuned
  wire         fault_now  = LOOP_FLAGS.open | LOOP_FLAGS.shorted | retuning_reg;
  wire [1:0]   code_live  = LOOP_FLAGS.open ? `CODE_OPEN :
                            LOOP_FLAGS.shorted ? `CODE_SHORT :
                            retuning_reg ? `CODE_CHANGE : `CODE_NONE;
  wire [1:0]   code_new   = LOOP_FLAGS.change ? `CODE_CHANGE : code_live;

  // A new fault wins over a clear arriving in the same cycle
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      code_reg       <= `CODE_NONE;
      retune_cnt_reg <= 32'h0;
      retuning_reg   <= 1'b0;
    end else if (CLK_EN) begin
      if (code_new != `CODE_NONE) begin
        code_reg <= code_new;
      end else if (clear_code) begin
        code_reg <= `CODE_NONE;
      end
      if (LOOP_FLAGS.change) begin
        retuning_reg   <= 1'b1;
        retune_cnt_reg <= 32'h0;
      end else if (retune_end) begin
        retuning_reg   <= 1'b0;
      end else if (retuning_reg) begin
        retune_cnt_reg <= retune_cnt_reg + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Detection sequence
  // ----------------------------------------
  // Sequence state, shared timer and presence hold counter
  det_state_t  state_reg;
  det_state_t  state_next;
  logic [31:0] timer_reg;
  logic [10:0] hold_reg;
  logic        hold_done_reg;
  // A fault or a held button hides the vehicle from the sequence
  wire         veh       = VEHICLE & enable_reg & ~fault_now & ~button_reg;
  wire         delay_end = (timer_reg == DELAY_CYC - 1);
  wire         ext_end   = (timer_reg == EXTEND_CYC - 1);

  // Next state of the delay, detect and extension sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (veh) begin
          state_next = cfg_reg.delay_en ? ST_DELAY : ST_DETECT;
        end
      end
      ST_DELAY: begin
        if (!veh) begin
          state_next = ST_IDLE;
        end else if (delay_end) begin
          state_next = ST_DETECT;
        end
      end
      ST_DETECT: begin
        if (!veh) begin
          state_next = cfg_reg.extend_en ? ST_EXTEND : ST_IDLE;
        end
      end
      ST_EXTEND: begin
        if (veh) begin
          state_next = ST_DETECT;
        end else if (ext_end) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Shared timer restarts on every state change; hold counts in ticks
  // Counting ticks keeps the hold counter small for a minutes-long hold
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg     <= ST_IDLE;
      timer_reg     <= 32'h0;
      hold_reg      <= 11'h000;
      hold_done_reg <= 1'b0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      timer_reg <= (state_next != state_reg) ? 32'h0 : timer_reg + 32'h1;
      if (state_reg != ST_DETECT || !cfg_reg.normal_pres) begin
        hold_reg      <= 11'h000;
        hold_done_reg <= 1'b0;
      end else if (tick && !hold_done_reg) begin
        hold_reg      <= hold_reg + 11'h001;
        hold_done_reg <= (hold_reg == 11'(HOLD_TICKS - 1));
      end
    end
  end

  // ----------------------------------------
  // Outputs and indicators
  // ----------------------------------------
  // Pulse generator and entry and exit edge detection
  logic [31:0] pulse_cnt_reg;
  logic        pulse_reg;
  logic        active_last_reg;
  // Hold release ends the detect output but not the state
  wire         det_active = ((state_reg == ST_DETECT) & ~hold_done_reg) |
                            (state_reg == ST_EXTEND);
  wire         pres_val   = fault_now ? ~cfg_reg.fail_secure : det_active;
  wire         entry_evt  = det_active & ~active_last_reg;
  wire         exit_evt   = ~det_active & active_last_reg;
  // Only the two pulse modes arm the pulse generator
  wire         pulse_trig = (cfg_reg.aux_mode == `AUX_ENTRY) ? entry_evt :
                            (cfg_reg.aux_mode == `AUX_EXIT) ? exit_evt : 1'b0;
  wire         pulse_end  = pulse_reg & (pulse_cnt_reg == PULSE_CYC - 1);
  // Aux source picked by the mode switches
  wire         aux_val    = (cfg_reg.aux_mode == `AUX_FAULT) ? fault_now :
                            (cfg_reg.aux_mode == `AUX_PRESENCE) ? pres_val :
                            pulse_reg;
  // Blink n times at 250 ms on/off, then rest for the rest of a 4 s frame
  wire         live_blink = (tick_cnt_reg < {1'b0, code_live, 1'b0}) & ~tick_cnt_reg[0];
  wire         code_blink = (tick_cnt_reg < {1'b0, code_reg, 1'b0}) & ~tick_cnt_reg[0];
  wire         detect_val = fault_now ? live_blink :
                            (state_reg == ST_DELAY) ? tick_cnt_reg[1] :
                            (state_reg == ST_EXTEND) ? tick_cnt_reg[0] :
                            det_active;
  // Stored code beats low supply on the power LED
  wire         power_val  = (code_reg != `CODE_NONE) ? code_blink :
                            LOOP_FLAGS.low_supply ? (tick_cnt_reg[2:0] != 3'h0) :
                            1'b1;
  // Boost spans delay and extension so a weak return is not lost
  wire         boost      = (state_reg != ST_IDLE);
  // Sensitivity rank 0 is low, 3 is high; switches 00 give medium-low
  wire [1:0]   sens_rank  = {cfg_reg.sens[1], cfg_reg.sens[1] ~^ cfg_reg.sens[0]};
  wire [1:0]   sens_val   = (boost && sens_rank != 2'h3) ? sens_rank + 2'h1 : sens_rank;

  // Pulse keeps its full length even if the mode switch moves mid pulse
  // A new trigger restarts a running pulse
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pulse_cnt_reg   <= 32'h0;
      pulse_reg       <= 1'b0;
      active_last_reg <= 1'b0;
    end else if (CLK_EN) begin
      active_last_reg <= det_active;
      if (pulse_trig) begin
        pulse_reg     <= 1'b1;
        pulse_cnt_reg <= 32'h0;
      end else if (pulse_end) begin
        pulse_reg     <= 1'b0;
      end else if (pulse_reg) begin
        pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
      end
    end
  end

  // All ports registered so the operator sees glitch-free levels
  // Inverted aux comes from the same source, never from AUX_OUT itself
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRESENCE_OUT <= 1'b0;
      AUX_OUT      <= 1'b0;
      AUX_OUT_N    <= 1'b1;
      DETECT_LED   <= 1'b0;
      POWER_LED    <= 1'b0;
      SENS_LEVEL   <= 2'h1;
      SENS_BOOST   <= 1'b0;
      FREQ_SEL     <= 2'h0;
      RETUNE       <= 1'b0;
    end else if (CLK_EN) begin
      PRESENCE_OUT <= pres_val;
      AUX_OUT      <= aux_val;
      AUX_OUT_N    <= ~aux_val;
      DETECT_LED   <= detect_val;
      POWER_LED    <= power_val;
      SENS_LEVEL   <= sens_val;
      SENS_BOOST   <= boost;
      FREQ_SEL     <= cfg_reg.freq;
      RETUNE       <= retune_end;
    end
  end

  // Status word seen by software
  // Bits above eleven read as zero
  assign status_word = {20'h0, tick_cnt_reg[0], retuning_reg, code_reg,
                        state_reg, hold_done_reg, fault_now,
                        POWER_LED, DETECT_LED, AUX_OUT, PRESENCE_OUT};
  // Bus outputs straight from their flops
  assign AVS_READDATA    = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;

endmodule // loop_det_ctrl

`default_nettype wire

/* File: tb/loop_det_ctrl_assertions.sv */
// Port-level assertions for the loop detector control block
`timescale 1ns/1ps
`default_nettype none
`include "loop_det_cfg.svh"

module loop_det_ctrl_assertions
  import loop_det_pkg::*;
#(
  parameter int RETUNE_CYC = 20
) (
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic        VEHICLE,
  input wire loop_flags_t LOOP_FLAGS,
  input wire sw_cfg_t     SWITCHES,
  input wire logic        RESET_BUTTON,
  input wire logic        PRESENCE_OUT,
  input wire logic        AUX_OUT,
  input wire logic        AUX_OUT_N,
  input wire logic        RETUNE,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST
);
  // Retune window, slack for the flag and output flops
  localparam int RT_LO = RETUNE_CYC - 3;
  localparam int RT_HI = RETUNE_CYC + 4;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  // ------
  // Sequences
  // ------
  // Quiet loop with delay armed, then a vehicle arrives
  sequence armed_entry;
    ($stable(SWITCHES) && SWITCHES.delay_en && !VEHICLE && !PRESENCE_OUT
      && LOOP_FLAGS[2:0] == 3'h0)[*8] ##1 VEHICLE;
  endsequence

  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered next cycle");
  a_wait_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_aux_inverse: assert property (AUX_OUT_N == !AUX_OUT)
    else $error("inverted aux output disagrees");
  a_retune_single: assert property (RETUNE |=> (!RETUNE)[*8])
    else $error("retune pulse repeated");
  a_retune_time: assert property ($fell(LOOP_FLAGS.change) |-> ##[RT_LO:RT_HI] RETUNE)
    else $error("retune not issued after the change fault");
  a_fault_aux: assert property ((LOOP_FLAGS.open && SWITCHES.aux_mode == `AUX_FAULT
      && $stable(SWITCHES) && !RESET_BUTTON)[*8] |-> AUX_OUT)
    else $error("aux output not conducting on loop fault");
  a_fail_safe: assert property ((LOOP_FLAGS.open && !SWITCHES.fail_secure
      && $stable(SWITCHES))[*8] |-> PRESENCE_OUT)
    else $error("presence not active on fault in fail-safe");
  a_fail_secure: assert property ((LOOP_FLAGS.open && SWITCHES.fail_secure
      && $stable(SWITCHES))[*8] |-> !PRESENCE_OUT)
    else $error("presence active on fault in fail-secure");
  a_infinite_pres: assert property ((VEHICLE && LOOP_FLAGS[2:0] == 3'h0 && !RESET_BUTTON
      && !SWITCHES.delay_en && !SWITCHES.normal_pres && $stable(SWITCHES))[*8] |-> PRESENCE_OUT)
    else $error("presence dropped while vehicle stays");
  a_delay_hold: assert property (armed_entry |-> (!PRESENCE_OUT)[*8] ##8 !PRESENCE_OUT)
    else $error("presence raised inside the detect delay");
endmodule // loop_det_ctrl_assertions

bind loop_det_ctrl loop_det_ctrl_assertions #(.RETUNE_CYC(RETUNE_CYC)) u_chk (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .VEHICLE(VEHICLE), .LOOP_FLAGS(LOOP_FLAGS),
  .SWITCHES(SWITCHES), .RESET_BUTTON(RESET_BUTTON), .PRESENCE_OUT(PRESENCE_OUT),
  .AUX_OUT(AUX_OUT), .AUX_OUT_N(AUX_OUT_N), .RETUNE(RETUNE), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST));
`default_nettype wire

/* File: tb/gate_operator_model.sv */
// Gate operator controller model that reads the two detector outputs
`timescale 1ns/1ps
`default_nettype none

module gate_operator_model (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [1:0]       lines,
  output logic      [1:0][15:0] hi_cnt,
  output logic      [1:0][15:0] hi_len
);
  logic [1:0][15:0] run_reg;

  // ------
  // Input sampling
  // ------
  // Counts conducting intervals and their length, as a controller input would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_reg <= '0;
      hi_cnt  <= '0;
      hi_len  <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        run_reg[k] <= lines[k] ? run_reg[k] + 16'h1 : 16'h0;
        if (!lines[k] && run_reg[k] != 16'h0) begin
          hi_cnt[k] <= hi_cnt[k] + 16'h1;
          hi_len[k] <= run_reg[k];
        end
      end
    end
  end
endmodule // gate_operator_model
`default_nettype wire

/* File: tb/loop_detector_output_control_tb.sv */
// Self-checking bench for the loop detector output control block
`timescale 1ns/1ps
`default_nettype none

module loop_detector_output_control_tb;
  import loop_det_pkg::*;
  localparam int DLY = 20;
  localparam int EXT = 50;
  localparam int PLS = 5;
  logic clk = 1'b0, rst = 1'b1, vehicle = 1'b0, button = 1'b0, rd = 1'b0, wr = 1'b0;
  logic ce = 1'b1;
  loop_flags_t flags = '0;
  sw_cfg_t sw = '0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic pres, aux, aux_n, det_led, pwr_led, boost, retune, waitreq;
  logic [1:0] sens, freq;
  logic [1:0][15:0] hi_cnt, hi_len;
  int mismatches = 0, tests_run = 0, cycles = 0, seed = 90550, t, e, len;
  logic [15:0] c0, a0;
  sw_cfg_t s;

  loop_det_ctrl #(.DELAY_CYC(DLY), .EXTEND_CYC(EXT), .PULSE_CYC(PLS), .RETUNE_CYC(20),
    .TICK_CYC(4), .DEBOUNCE_CYC(3), .HOLD_TICKS(10)) i_dut (
    .SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .VEHICLE(vehicle), .LOOP_FLAGS(flags),
    .SWITCHES(sw), .RESET_BUTTON(button), .PRESENCE_OUT(pres), .AUX_OUT(aux),
    .AUX_OUT_N(aux_n), .DETECT_LED(det_led), .POWER_LED(pwr_led), .SENS_LEVEL(sens),
    .SENS_BOOST(boost), .FREQ_SEL(freq), .RETUNE(retune), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq));
  gate_operator_model i_gate (.clk(clk), .rst(rst), .lines({aux, pres}), .hi_cnt(hi_cnt),
    .hi_len(hi_len));

  // ------
  // Clock, timeout and checking helpers
  // ------
  always #5 clk = ~clk;
  // Whole run needs about 1800 cycles; a hang ends here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  // Switch code to rank: 00 med-low, 01 low, 10 med-high, 11 high; boost capped
  function automatic logic [1:0] rank(input logic [1:0] c, input logic b);
    logic [1:0] r;
    r = (c == 2'h0) ? 2'h1 : (c == 2'h1) ? 2'h0 : c;
    return (b && r != 2'h3) ? r + 2'h1 : r;
  endfunction
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", n, x, g);
    end
  endtask
  // Lengths may shift by a flop or two at either end
  task automatic near(input string n, input int x, input logic [15:0] g);
    cmp(n, x, (g + 2 >= x && g <= x + 2) ? x : g);
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Counts LED transitions across n cycles
  task automatic toggles(input logic p, input int n, output int cnt);
    logic v, o;
    cnt = 0;
    o = p ? pwr_led : det_led;
    repeat (n) begin
      @(posedge clk);
      v = p ? pwr_led : det_led;
      cnt += (v !== o);
      o = v;
    end
  endtask
  task automatic setsw(input sw_cfg_t x);
    sw <= x;
    repeat (12) @(posedge clk);
    c0 = hi_cnt[0];
    a0 = hi_cnt[1];
  endtask
  task automatic press();
    button <= 1'b1;
    repeat (10) @(posedge clk);
    button <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 4'h8, 32'h0);
    cmp("ctrl", 32'h1, q);
    bus(1'b1, 4'hC, 32'hFF);
    bus(1'b0, 4'hC, 32'h0);
    cmp("unmapped", 32'h0, q);
    // Random switches with every aux mode and delay/extension mix
    for (int i = 0; i < 8; i++) begin
      s = 10'($random(seed));
      s.normal_pres = 1'b0;
      s.aux_mode = i[1:0];
      s.delay_en = i[2];
      s.extend_en = i[0];
      setsw(s);
      bus(1'b0, 4'h4, 32'h0);
      cmp("switch reg", s, q[9:0]);
      cmp("freq", s.freq, freq);
      cmp("vacant sens", rank(s.sens, 1'b0), sens);
      len = 25 + ({$random(seed)} % 16);
      vehicle <= 1'b1;
      if (s.delay_en) begin
        repeat (4) @(posedge clk);
        toggles(1'b0, 16, t);
        cmp("delay flash", 2, t);
        repeat (len - 20) @(posedge clk);
      end else repeat (len) @(posedge clk);
      cmp("boost", 1'b1, boost);
      cmp("boosted sens", rank(s.sens, 1'b1), sens);
      cmp("detect led", 1'b1, det_led);
      vehicle <= 1'b0;
      if (s.extend_en) begin
        repeat (5) @(posedge clk);
        toggles(1'b0, 16, t);
        cmp("extend flash", 4, t);
        repeat (49) @(posedge clk);
      end else repeat (70) @(posedge clk);
      e = len - (s.delay_en ? DLY : 0) + (s.extend_en ? EXT : 0);
      cmp("presence count", c0 + 1, hi_cnt[0]);
      near("presence len", e, hi_len[0]);
      cmp("aux count", a0 + (s.aux_mode != 2'h0), hi_cnt[1]);
      if (s.aux_mode == 2'h2) near("aux copy len", e, hi_len[1]);
      else if (s.aux_mode != 2'h0) cmp("pulse len", PLS, hi_len[1]);
      cmp("boost off", 1'b0, boost);
    end
    // Vehicle leaves inside the delay
    setsw(10'h040);
    vehicle <= 1'b1;
    repeat (10) @(posedge clk);
    vehicle <= 1'b0;
    repeat (30) @(posedge clk);
    cmp("abandoned", c0, hi_cnt[0]);
    // Re-entry during the extension keeps one unbroken output
    setsw(10'h080);
    vehicle <= 1'b1;
    repeat (30) @(posedge clk);
    vehicle <= 1'b0;
    repeat (20) @(posedge clk);
    vehicle <= 1'b1;
    repeat (10) @(posedge clk);
    vehicle <= 1'b0;
    repeat (70) @(posedge clk);
    cmp("reentry count", c0 + 1, hi_cnt[0]);
    near("reentry len", 110, hi_len[0]);
    // Normal presence lets go of a parked vehicle
    setsw(10'h100);
    vehicle <= 1'b1;
    repeat (80) @(posedge clk);
    cmp("hold release", c0 + 1, hi_cnt[0]);
    vehicle <= 1'b0;
    // Open then shorted loop; cleared by register, then by button
    setsw(10'h000);
    toggles(1'b1, 64, t);
    cmp("power steady", 0, t);
    for (int c = 1; c < 3; c++) begin
      flags <= loop_flags_t'(4'h1 << (c - 1));
      repeat (10) @(posedge clk);
      cmp("fault aux", 1'b1, aux);
      cmp("fail safe", 1'b1, pres);
      toggles(1'b0, 64, t);
      cmp("blink code", 2 * c, t);
      bus(1'b0, 4'h0, 32'h0);
      cmp("stored code", c, q[9:8]);
      flags <= '0;
      repeat (10) @(posedge clk);
      cmp("healed aux", 1'b0, aux);
      if (c == 1) bus(1'b1, 4'h8, 32'h3);
      else press();
      bus(1'b0, 4'h0, 32'h0);
      cmp("code cleared", 2'h0, q[9:8]);
    end
    // Inductance change: retune, resume, power LED keeps the code
    flags <= 4'h4;
    @(posedge clk);
    flags <= '0;
    while (retune !== 1'b1) @(posedge clk);
    toggles(1'b1, 64, t);
    cmp("stored blink", 6, t);
    c0 = hi_cnt[0];
    vehicle <= 1'b1;
    repeat (20) @(posedge clk);
    vehicle <= 1'b0;
    repeat (10) @(posedge clk);
    cmp("resumed", c0 + 1, hi_cnt[0]);
    press();
    // Low supply blink, then fail-secure fault
    flags <= 4'h8;
    repeat (4) @(posedge clk);
    toggles(1'b1, 64, t);
    cmp("low supply", 4, t);
    flags <= '0;
    setsw(10'h200);
    flags <= 4'h1;
    repeat (10) @(posedge clk);
    cmp("fail secure", 1'b0, pres);
    flags <= '0;
    repeat (10) @(posedge clk);
    // Clock enable low freezes aux until it returns
    ce <= 1'b0;
    flags <= 4'h1;
    repeat (5) @(posedge clk);
    cmp("frozen aux", 1'b0, aux);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    cmp("thawed aux", 1'b1, aux);
    flags <= '0;
    repeat (10) @(posedge clk);
    results();
  end
endmodule // loop_detector_output_control_tb
`default_nettype wire
